// file: src/hsp_pkg.sv
// Package for the Hall-synchronised sine PWM generator: constants and types
package hsp_pkg;
	// Clock and carrier timing
	localparam int HSP_CLK_HZ = 100_000_000;
	localparam int HSP_CARRIER_HZ = 20_000;
	localparam int HSP_CARRIER_CYC = HSP_CLK_HZ / HSP_CARRIER_HZ;
	localparam int HSP_CNT_W = 13;
	// Deadband time in ns, rounded up to whole cycles
	localparam int HSP_DEAD_NS = 500;
	localparam int HSP_CLK_NS = 10;
	localparam int HSP_DEAD_CYC = (HSP_DEAD_NS + HSP_CLK_NS - 1) / HSP_CLK_NS;
	// Angle accumulator and sine table
	localparam int HSP_ACC_W = 16;
	localparam int HSP_IDX_W = 8;
	localparam int HSP_TBL_N = 256;
	localparam int HSP_MAG_W = 8;
	localparam int HSP_CAP_W = 16;
	// Angle offsets: 60, 120 and 240 degrees in accumulator units
	localparam logic [15:0] HSP_DEG120 = 16'h5555;
	localparam logic [15:0] HSP_DEG240 = 16'hAAAB;
	localparam logic [15:0] HSP_DEG60 = 16'h2AAB;
	// Hall codes treated as invalid
	localparam logic [2:0] HSP_HALL_ZERO = 3'h0;
	localparam logic [2:0] HSP_HALL_ONES = 3'h7;
	// Hall state at which the period capture is presented
	localparam logic [2:0] HSP_HALL_REF = 3'h1;
	// Update engine states
	typedef enum logic [3:0] {
		HSP_IDLE  = 4'b0001,
		HSP_FETCH = 4'b0010,
		HSP_SCALE = 4'b0100,
		HSP_LOAD  = 4'b1000
	} hsp_upd_t;
endpackage

// file: src/hsp_pair.sv
// One complementary PWM pair with deadband and trip gating
`timescale 1ns/1ns
module hsp_pair
	import hsp_pkg::*;
#(
	parameter int CNT_W = HSP_CNT_W,
	parameter int DEAD = HSP_DEAD_CYC
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [CNT_W-1:0] cnt,
	input wire logic [CNT_W-1:0] duty,
	input wire logic kill,
	output logic out_hi,
	output logic out_lo
);
	logic want_hi; // Raw compare result
	logic [CNT_W-1:0] dead_cnt; // Deadband down-counter
	logic last_want; // Previous raw compare

	assign want_hi = (cnt < duty);

	// Deadband counter restarts on every edge of the raw compare and on kill
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			last_want <= 1'b0;
			dead_cnt <= '0;
		end else begin
			last_want <= want_hi;
			// A short trip must not let the low side follow the high side at once
			if (kill || (want_hi != last_want)) begin
				dead_cnt <= CNT_W'(DEAD);
			end else if (dead_cnt != '0) begin
				dead_cnt <= dead_cnt - 1'b1;
			end
		end
	end

	// Outputs registered; kill wins immediately, both sides off
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			out_hi <= 1'b0;
			out_lo <= 1'b0;
		end else if (kill) begin
			out_hi <= 1'b0;
			out_lo <= 1'b0;
		end else begin
			// Only one side may be on, and only after the dead time
			out_hi <= want_hi && last_want && (dead_cnt == '0);
			out_lo <= !want_hi && !last_want && (dead_cnt == '0);
		end
	end
endmodule // hsp_pair

// file: src/hsp_top.sv
// Top of the Hall-synchronised three-phase sine PWM generator
`timescale 1ns/1ns
module hsp_top
	import hsp_pkg::*;
#(
	parameter int CARRIER = HSP_CARRIER_CYC,
	parameter int DEAD = HSP_DEAD_CYC
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic run,
	input wire logic dir_rev,
	input wire logic [HSP_MAG_W-1:0] magnitude,
	input wire logic [2:0] hall,
	input wire logic trip,
	input wire logic overcurrent,
	output logic [2:0] pwm_hi,
	output logic [2:0] pwm_lo,
	output logic hall_event,
	output logic [2:0] commutation,
	output logic [HSP_CAP_W-1:0] period_capture,
	output logic period_valid,
	output logic hall_fault,
	output logic [HSP_ACC_W-1:0] speed_step
);
	// Carrier counter and tick
	logic [HSP_CNT_W-1:0] carrier_cnt;
	logic tick;
	// Sine table, amplitude 0..254 centred on 127.5
	logic [7:0] sine_tbl [HSP_TBL_N];
	// Phase accumulator and per-tick step
	logic [HSP_ACC_W-1:0] theta;
	logic [HSP_ACC_W-1:0] step;
	// Update engine
	hsp_upd_t upd;
	logic [7:0] raw [3];
	logic [HSP_CNT_W-1:0] scaled [3];
	logic [HSP_CNT_W-1:0] duty [3];
	// Hall handling
	logic [2:0] hall_q;
	logic hall_seen;
	logic [HSP_CAP_W-1:0] cap_timer;
	logic [HSP_ACC_W-1:0] hall_angle;
	logic oc_latch;
	logic kill;
	logic [15:0] off_b;
	logic [15:0] off_c;
	logic [HSP_ACC_W-1:0] next_theta;

	// Table filled once with a sine, constant contents
	initial begin
		for (int i = 0; i < HSP_TBL_N; i++) begin
			sine_tbl[i] = 8'($rtoi(127.5 + 127.0 * $sin(6.283185307 * i / HSP_TBL_N)));
		end
	end

	// Fixed-rate carrier counter, tick at end of period
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			carrier_cnt <= '0;
		end else if (carrier_cnt == HSP_CNT_W'(CARRIER - 1)) begin
			carrier_cnt <= '0;
		end else begin
			carrier_cnt <= carrier_cnt + 1'b1;
		end
	end
	assign tick = (carrier_cnt == HSP_CNT_W'(CARRIER - 1));

	// Reverse direction swaps the B and C offsets
	assign off_b = dir_rev ? HSP_DEG240 : HSP_DEG120;
	assign off_c = dir_rev ? HSP_DEG120 : HSP_DEG240;

	// Hall code to sector-start angle, mirrored in reverse
	function automatic logic [15:0] hsp_sector(input logic [2:0] h, input logic rev);
		logic [2:0] s;
		s = 3'h0;
		unique case (h)
			3'h1: s = 3'h0;
			3'h3: s = 3'h1;
			3'h2: s = 3'h2;
			3'h6: s = 3'h3;
			3'h4: s = 3'h4;
			3'h5: s = 3'h5;
			default: s = 3'h0;
		endcase
		// Reverse walks the sectors backward, so negate the angle
		if (rev) begin
			return 16'(16'h0000 - 16'(s) * HSP_DEG60);
		end
		return 16'(16'(s) * HSP_DEG60);
	endfunction
	assign hall_angle = hsp_sector(hall, dir_rev);

	// Hall edge detector; one common handler below
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			hall_q <= 3'h0;
			hall_seen <= 1'b0;
			hall_event <= 1'b0;
		end else begin
			hall_q <= hall;
			hall_seen <= 1'b1;
			hall_event <= hall_seen && (hall != hall_q);
		end
	end

	// Common Hall handler: commutation state and fault flag
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			commutation <= 3'h0;
			hall_fault <= 1'b0;
		end else if (hall == HSP_HALL_ZERO || hall == HSP_HALL_ONES) begin
			hall_fault <= 1'b1;
		end else begin
			// A valid code clears the fault and updates the state
			hall_fault <= 1'b0;
			commutation <= hall;
		end
	end

	// Free capture timer, restarted each Hall edge, latched on the edge into the reference state
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cap_timer <= '0;
			period_capture <= '0;
			period_valid <= 1'b0;
		end else if (hall_seen && hall != hall_q) begin
			cap_timer <= '0;
			// Presented only at the reference state; holds the last sector time
			if (hall == HSP_HALL_REF) begin
				period_capture <= cap_timer;
			end
			period_valid <= (hall == HSP_HALL_REF);
		end else begin
			period_valid <= 1'b0;
			// Saturate so a stalled motor reads full scale
			if (cap_timer != '1) begin
				cap_timer <= cap_timer + 1'b1;
			end
		end
	end

	// Step re-estimated from the per-sector tick count
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			step <= '0;
		end else if (hall_seen && hall != hall_q && cap_timer != '0) begin
			// One sector is 60 deg; step = sector angle / (whole carrier periods + 1)
			step <= 16'(HSP_DEG60 / (32'(cap_timer) / 32'(CARRIER) + 32'h1));
		end
	end
	assign speed_step = step;

	// Angle: Hall-snapped at start and on every edge, else integrated
	always_comb begin
		next_theta = theta;
		if (!hall_seen || (hall != hall_q)) begin
			next_theta = hall_angle;
		end else if (tick) begin
			next_theta = dir_rev ? theta - step : theta + step;
		end
	end
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			theta <= '0;
		end else begin
			theta <= next_theta;
		end
	end

	// Update engine: fetch, scale, then load all duties at once
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			upd <= HSP_IDLE;
			for (int p = 0; p < 3; p++) begin
				raw[p] <= '0;
				scaled[p] <= '0;
				duty[p] <= '0;
			end
		end else begin
			unique case (upd)
				HSP_IDLE: if (tick) begin
					upd <= HSP_FETCH;
				end
				HSP_FETCH: begin
					// Same table, A at theta, B and C at their offsets, upper byte as index
					raw[0] <= sine_tbl[theta[15:8]];
					raw[1] <= sine_tbl[8'((theta + off_b) >> 8)];
					raw[2] <= sine_tbl[8'((theta + off_c) >> 8)];
					upd <= HSP_SCALE;
				end
				HSP_SCALE: begin
					for (int p = 0; p < 3; p++) begin
						// Same magnitude for every phase, full scale is one period
						scaled[p] <= HSP_CNT_W'((32'(raw[p]) * 32'(magnitude) * 32'(CARRIER)) >> 16);
					end
					upd <= HSP_LOAD;
				end
				HSP_LOAD: begin
					// All three loaded together, off when not running
					for (int p = 0; p < 3; p++) begin
						duty[p] <= run ? scaled[p] : '0;
					end
					upd <= HSP_IDLE;
				end
			endcase
		end
	end

	// Overcurrent holds off to end of carrier, then releases
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			oc_latch <= 1'b0;
		end else if (overcurrent) begin
			oc_latch <= 1'b1;
		end else if (tick) begin
			oc_latch <= 1'b0;
		end
	end
	assign kill = trip || overcurrent || oc_latch || hall_fault;

	// Three identical pairs drive the bridge
	for (genvar g = 0; g < 3; g++) begin : g_pair
		hsp_pair #(.CNT_W(HSP_CNT_W), .DEAD(DEAD)) u_pair (
			.sys_clk(sys_clk),
			.rst_b(rst_b),
			.cnt(carrier_cnt),
			.duty(duty[g]),
			.kill(kill),
			.out_hi(pwm_hi[g]),
			.out_lo(pwm_lo[g])
		);
	end
endmodule // hsp_top

// file: verif/hsp_monitor.sv
// Port checker for the Hall-synced sine PWM top
`timescale 1ns/1ns
module hsp_monitor
	import hsp_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic trip,
	input wire logic overcurrent,
	input wire logic [2:0] hall,
	input wire logic [2:0] pwm_hi,
	input wire logic [2:0] pwm_lo,
	input wire logic hall_event,
	input wire logic [2:0] commutation,
	input wire logic period_valid,
	input wire logic hall_fault
);
	// One domain; reset silences everything
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	// Shoot-through would short the bridge leg
	a_no_overlap: assert property ((pwm_hi & pwm_lo) == 3'h0)
		else $error("leg overlap");
	a_dead_gap: assert property ($fell(pwm_hi[0]) |-> !pwm_lo[0] [*4])
		else $error("no dead gap");
	a_trip_off: assert property (trip |=> (pwm_hi | pwm_lo) == 3'h0)
		else $error("trip ignored");
	a_oc_off: assert property (overcurrent |=> (pwm_hi | pwm_lo) == 3'h0)
		else $error("overcurrent ignored");
	a_edge_event: assert property (hall != $past(hall) |=> hall_event)
		else $error("missed hall event");
	a_event_cause: assert property (hall_event |-> $past(hall, 2) != $past(hall))
		else $error("spurious hall event");
	a_ref_capture: assert property (period_valid |-> hall_event && $past(hall) == HSP_HALL_REF)
		else $error("capture off reference");
	a_valid_pulse: assert property (period_valid |=> !period_valid)
		else $error("capture pulse long");
	a_bad_flag: assert property (1'b1 |-> hall_fault == ($past(hall) == 3'h0 || $past(hall) == 3'h7))
		else $error("fault flag wrong");
	a_bad_hold: assert property (hall_fault |-> $stable(commutation))
		else $error("state moved on bad hall");
	a_comm_track: assert property ($rose(hall_event) && !hall_fault |-> ##[0:2] commutation == hall)
		else $error("commutation lags");
endmodule // hsp_monitor

bind hsp_top hsp_monitor chk_i (
	.sys_clk(sys_clk),
	.rst_b(rst_b),
	.trip(trip),
	.overcurrent(overcurrent),
	.hall(hall),
	.pwm_hi(pwm_hi),
	.pwm_lo(pwm_lo),
	.hall_event(hall_event),
	.commutation(commutation),
	.period_valid(period_valid),
	.hall_fault(hall_fault)
);

// file: verif/hsp_motor.sv
// Motor Hall sensor model with fault injection
`timescale 1ns/1ns
module hsp_motor (
	input wire logic [2:0] sector,
	input wire logic [2:0] force_code,
	input wire logic use_force,
	output logic [2:0] hall
);
	// Six codes per turn, sixty degrees apart
	always_comb begin
		case (sector)
			3'h0: hall = 3'h1;
			3'h1: hall = 3'h3;
			3'h2: hall = 3'h2;
			3'h3: hall = 3'h6;
			3'h4: hall = 3'h4;
			default: hall = 3'h5;
		endcase
		// Broken sensor overrides the wheel
		if (use_force) begin
			hall = force_code;
		end
	end
endmodule // hsp_motor

// file: verif/tb_top.sv
// Self-checking bench for the sine PWM generator
`timescale 1ns/1ns
module tb_top;
	import hsp_pkg::*;
	localparam int CAR = 200; // Short carrier keeps the run brief
	logic sys_clk = 0, rst_b = 0, run = 0, dir_rev = 0, trip = 0, overcurrent = 0, use_force = 0;
	logic [7:0] magnitude = 8'h00;
	logic [2:0] sector = 3'h0, force_code = 3'h0, hall, pwm_hi, pwm_lo, commutation;
	logic hall_event, period_valid, hall_fault;
	logic [15:0] period_capture, speed_step;
	int bad_count = 0, num_checks = 0, cyc = 0;
	always #5 sys_clk = ~sys_clk;
	hsp_motor motor (.sector(sector), .force_code(force_code), .use_force(use_force), .hall(hall));
	hsp_top #(.CARRIER(CAR), .DEAD(5)) uut (.sys_clk(sys_clk), .rst_b(rst_b), .run(run), .dir_rev(dir_rev),
		.magnitude(magnitude), .hall(hall), .trip(trip), .overcurrent(overcurrent), .pwm_hi(pwm_hi),
		.pwm_lo(pwm_lo), .hall_event(hall_event), .commutation(commutation), .period_capture(period_capture),
		.period_valid(period_valid), .hall_fault(hall_fault), .speed_step(speed_step));
	task automatic nx(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Note which legs ever switch on
	task automatic watch(output logic [2:0] h, output logic [2:0] l);
		h = 3'h0;
		l = 3'h0;
		repeat (3 * CAR) begin
			@(negedge sys_clk);
			h |= pwm_hi;
			l |= pwm_lo;
		end
	endtask
	// All legs switch; carrier period from high-side rises
	task automatic t_run;
		logic [2:0] h, l;
		longint t0;
		run = 1;
		magnitude = 8'hFF;
		watch(h, l);
		chk(16'(h), 16'h7);
		chk(16'(l), 16'h7);
		@(posedge pwm_hi[0]);
		t0 = $time;
		@(posedge pwm_hi[0]);
		chk(16'(($time - t0) / 10), 16'(CAR));
		nx(1);
	endtask
	// One turn of Hall steps
	task automatic t_hall;
		for (int i = 1; i <= 6; i++) begin
			sector = 3'(i % 6);
			// Event pulse stands only for the cycle after the sampling edge
			nx(1);
			chk(16'(hall_event), 16'h1);
			chk(16'(period_valid), 16'(hall == HSP_HALL_REF));
			nx(40);
			chk(16'(commutation), 16'(hall));
		end
		chk(16'(period_capture != 16'h0), 16'h1);
		// Sectors shorter than a carrier period advance a whole sector per tick
		chk(speed_step, HSP_DEG60);
	endtask
	// Kill mid-pulse, by trip or overcurrent
	task automatic t_kill(input bit oc);
		@(posedge pwm_hi[0]);
		nx(1);
		if (oc) begin
			overcurrent = 1;
		end else begin
			trip = 1;
		end
		nx(1);
		chk(16'(pwm_hi | pwm_lo), 16'h0);
		overcurrent = 0;
	endtask
	task automatic t_dir;
		logic [2:0] h, l;
		watch(h, l);
		chk(16'(h), 16'h7);
		dir_rev = 1;
		sector = 3'h5;
		nx(3);
		chk(16'(commutation), 16'(hall));
		watch(h, l);
		chk(16'(h | l), 16'h7);
		dir_rev = 0;
		sector = 3'h0;
		nx(3);
	endtask
	// Both illegal codes refused
	task automatic t_fault;
		use_force = 1;
		for (int k = 0; k < 2; k++) begin
			force_code = k ? 3'h7 : 3'h0;
			nx(2);
			chk(16'(hall_fault), 16'h1);
			chk(16'(commutation), 16'h1);
			nx(2);
			chk(16'(pwm_hi | pwm_lo), 16'h0);
		end
		use_force = 0;
		nx(2);
		chk(16'(hall_fault), 16'h0);
	endtask
	task automatic stop_test;
		$display("checks %0d errors %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Hang guard
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			stop_test();
		end
	end
	initial begin
		// Five rising edges inside reset, release on a falling edge
		nx(5);
		rst_b = 1;
		t_run();
		t_hall();
		t_kill(1'b1);
		t_dir();
		t_fault();
		t_kill(1'b0);
		stop_test();
	end
endmodule // tb_top
